//--- src/pief_defines.svh
// register offsets, field positions, reset values and bus codes of the irq enable/flag bank
`ifndef PIEF_DEFINES_SVH
`define PIEF_DEFINES_SVH

`define PIEF_OFF_ENABLE_TWO 8'h00
`define PIEF_OFF_ENABLE_THREE 8'h04
`define PIEF_OFF_ENABLE_FOUR 8'h08
`define PIEF_OFF_REQUEST_ONE 8'h0c
`define PIEF_OFF_CONTROL 8'h10

`define PIEF_MASK_ENABLE_TWO 8'hff
`define PIEF_MASK_ENABLE_THREE 8'h10
`define PIEF_MASK_ENABLE_FOUR 8'h77
`define PIEF_MASK_REQUEST_ONE_RW 8'hcf
`define PIEF_MASK_CONTROL 8'hc0

`define PIEF_RESET_VALUE 8'h00

`define PIEF_BIT_GLOBAL_EN 7
`define PIEF_BIT_PERIPH_EN 6
`define PIEF_BIT_SERIAL_RX 5
`define PIEF_BIT_SERIAL_TX 4

`define PIEF_RESP_OKAY 2'h0
`define PIEF_RESP_SLVERR 2'h2

`endif

//--- src/pief_pkg.sv
// types shared by the irq enable/flag bank
package pief_pkg;
    typedef logic [7:0] pief_byte_t;
    typedef logic [7:0] pief_addr_t;
    typedef logic [1:0] pief_resp_t;
    typedef enum logic [1:0] {
        PIEF_WR_COLLECT = 2'b01,
        PIEF_WR_RESP = 2'b10
    } pief_wr_state_t;
    typedef enum logic [2:0] {
        PIEF_RD_IDLE = 3'b001,
        PIEF_RD_FETCH = 3'b010,
        PIEF_RD_RESP = 3'b100
    } pief_rd_state_t;
endpackage

//--- src/pief_regbus_if.sv
// internal register access carrier between bus slave and register bank
`timescale 1ns/10ps
interface pief_regbus_if;
    import pief_pkg::*;
    logic wr_en;
    pief_addr_t wr_addr;
    pief_byte_t wr_data;
    logic wr_hit;
    pief_addr_t rd_addr;
    pief_byte_t rd_data;
    logic rd_hit;

    modport bus (
        output wr_en,
        output wr_addr,
        output wr_data,
        output rd_addr,
        input wr_hit,
        input rd_data,
        input rd_hit
    );
    modport regs (
        input wr_en,
        input wr_addr,
        input wr_data,
        input rd_addr,
        output wr_hit,
        output rd_data,
        output rd_hit
    );
endinterface

//--- src/pief_axil_slave.sv
// axi4-lite slave that turns bus transfers into byte register accesses
`timescale 1ns/10ps
`include "pief_defines.svh"
module pief_axil_slave (
    input wire logic aclk,
    input wire logic aresetn,
    input wire pief_pkg::pief_addr_t awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output pief_pkg::pief_resp_t bresp,
    output logic bvalid,
    input wire logic bready,
    input wire pief_pkg::pief_addr_t araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output pief_pkg::pief_resp_t rresp,
    output logic rvalid,
    input wire logic rready,
    pief_regbus_if.bus rb
);
    import pief_pkg::*;

    pief_wr_state_t wr_state, next_wr_state;
    logic aw_got, next_aw_got, w_got, next_w_got, lane_ok, next_lane_ok;
    logic next_awready, next_wready, next_bvalid;
    pief_addr_t wr_addr_q, next_wr_addr_q;
    pief_byte_t wr_data_q, next_wr_data_q;
    pief_resp_t next_bresp;

    ////////////////////////////////////////////////////////////////////////////////
    // write: address and data are taken independently, committed once both are here
    always_comb begin
        next_wr_state = wr_state;
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_lane_ok = lane_ok;
        next_wr_addr_q = wr_addr_q;
        next_wr_data_q = wr_data_q;
        next_bvalid = bvalid;
        next_bresp = bresp;
        rb.wr_en = 1'b0;
        unique case (wr_state)
            PIEF_WR_COLLECT: begin
                if (awvalid && awready) begin
                    next_aw_got = 1'b1;
                    next_wr_addr_q = awaddr;
                end
                if (wvalid && wready) begin
                    next_w_got = 1'b1;
                    next_wr_data_q = wdata[7:0];
                    next_lane_ok = wstrb[0];
                end
                if (aw_got && w_got) begin
                    // only byte lane 0 carries register bits; other lanes are dropped
                    rb.wr_en = lane_ok;
                    next_bvalid = 1'b1;
                    next_bresp = rb.wr_hit ? `PIEF_RESP_OKAY : `PIEF_RESP_SLVERR;
                    next_aw_got = 1'b0;
                    next_w_got = 1'b0;
                    next_wr_state = PIEF_WR_RESP;
                end
            end
            PIEF_WR_RESP: begin
                if (bready) begin
                    next_bvalid = 1'b0;
                    next_wr_state = PIEF_WR_COLLECT;
                end
            end
        endcase
        next_awready = (next_wr_state == PIEF_WR_COLLECT) && !next_aw_got;
        next_wready = (next_wr_state == PIEF_WR_COLLECT) && !next_w_got;
    end

    assign rb.wr_addr = wr_addr_q;
    assign rb.wr_data = wr_data_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= PIEF_WR_COLLECT;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            lane_ok <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `PIEF_RESP_OKAY;
        end else begin
            wr_state <= next_wr_state;
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            lane_ok <= next_lane_ok;
            wr_addr_q <= next_wr_addr_q;
            wr_data_q <= next_wr_data_q;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read: one cycle to look the register up, then hold the answer until taken
    pief_rd_state_t rd_state, next_rd_state;
    pief_addr_t rd_addr_q, next_rd_addr_q;
    logic next_arready, next_rvalid;
    logic [31:0] next_rdata;
    pief_resp_t next_rresp;

    always_comb begin
        next_rd_state = rd_state;
        next_rd_addr_q = rd_addr_q;
        next_arready = arready;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        unique case (rd_state)
            PIEF_RD_IDLE: begin
                next_arready = 1'b1;
                if (arvalid && arready) begin
                    next_rd_addr_q = araddr;
                    next_arready = 1'b0;
                    next_rd_state = PIEF_RD_FETCH;
                end
            end
            PIEF_RD_FETCH: begin
                next_rdata = {24'h000000, rb.rd_data};
                next_rresp = rb.rd_hit ? `PIEF_RESP_OKAY : `PIEF_RESP_SLVERR;
                next_rvalid = 1'b1;
                next_rd_state = PIEF_RD_RESP;
            end
            PIEF_RD_RESP: begin
                if (rready) begin
                    next_rvalid = 1'b0;
                    next_arready = 1'b1;
                    next_rd_state = PIEF_RD_IDLE;
                end
            end
        endcase
    end

    assign rb.rd_addr = rd_addr_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= PIEF_RD_IDLE;
            rd_addr_q <= 8'h00;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `PIEF_RESP_OKAY;
        end else begin
            rd_state <= next_rd_state;
            rd_addr_q <= next_rd_addr_q;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end
endmodule

//--- src/pief_pending_flags.sv
// pending flag register: sticky writable flags and read-only mirrored status flags
`timescale 1ns/10ps
`include "pief_defines.svh"
module pief_pending_flags #(
    parameter int WIDTH = 8,
    parameter logic [7:0] RW_MASK = `PIEF_MASK_REQUEST_ONE_RW
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] next_flags;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        if (RW_MASK[i]) begin : g_rw
            // a source pulse in the same cycle as a software clear keeps the flag set
            assign next_flags[i] = set_in[i] | (wr_en ? wr_data[i] : flags[i]);
        end else begin : g_ro
            // status mirrored from its source; software writes have no effect
            assign next_flags[i] = set_in[i];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end
endmodule

//--- src/pief_bank.sv
// peripheral irq enable registers two to four, request register one and combined request
//
// Notes on behaviour
// - enable two: eight read/write enables, one enables, zero disables.
// - enable three: only bit 4 exists; all other bits read zero.
// - enable four: bits 6..4 timebase enables; bits 7 and 3 read zero.
// - enable four: bits 2..0 auto-shutdown enables for pwm three, two, one.
// - no peripheral request reaches the core unless the peripheral enable is set.
// - request one holds eight pending flags, one means pending.
// - receive and transmit flags are read-only; the other six are read/write.
// - flags set on their source event regardless of any enable bit.
// - every implemented enable and flag bit clears on any reset.
// - global enable at zero blocks every request to the core.
// - peripheral enable at one passes enabled requests when global enable is one, at zero blocks them.
`timescale 1ns/10ps
`include "pief_defines.svh"
module pief_bank (
    input wire logic aclk,
    input wire logic aresetn,
    input wire pief_pkg::pief_addr_t s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output pief_pkg::pief_resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire pief_pkg::pief_addr_t s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output pief_pkg::pief_resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pief_pkg::pief_byte_t request_one_src,
    input wire pief_pkg::pief_byte_t pending_two,
    input wire pief_pkg::pief_byte_t pending_three,
    input wire pief_pkg::pief_byte_t pending_four,
    output logic peripheral_irq
);
    import pief_pkg::*;

    pief_regbus_if rb ();

    pief_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .rb(rb.bus)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // address decode
    pief_addr_t wr_word, rd_word;
    logic wr_two, wr_three, wr_four, wr_req_one, wr_ctrl;

    assign wr_word = {rb.wr_addr[7:2], 2'b00};
    assign rd_word = {rb.rd_addr[7:2], 2'b00};
    assign wr_two = rb.wr_en && (wr_word == `PIEF_OFF_ENABLE_TWO);
    assign wr_three = rb.wr_en && (wr_word == `PIEF_OFF_ENABLE_THREE);
    assign wr_four = rb.wr_en && (wr_word == `PIEF_OFF_ENABLE_FOUR);
    assign wr_req_one = rb.wr_en && (wr_word == `PIEF_OFF_REQUEST_ONE);
    assign wr_ctrl = rb.wr_en && (wr_word == `PIEF_OFF_CONTROL);
    assign rb.wr_hit = (wr_word == `PIEF_OFF_ENABLE_TWO) || (wr_word == `PIEF_OFF_ENABLE_THREE)
        || (wr_word == `PIEF_OFF_ENABLE_FOUR) || (wr_word == `PIEF_OFF_REQUEST_ONE)
        || (wr_word == `PIEF_OFF_CONTROL);

    ////////////////////////////////////////////////////////////////////////////////
    // enable and control registers
    pief_byte_t enable_two, enable_three, enable_four, control;
    pief_byte_t next_enable_two, next_enable_three, next_enable_four, next_control;

    always_comb begin
        next_enable_two = enable_two;
        next_enable_three = enable_three;
        next_enable_four = enable_four;
        next_control = control;
        if (wr_two) begin
            next_enable_two = rb.wr_data & `PIEF_MASK_ENABLE_TWO;
        end
        if (wr_three) begin
            next_enable_three = rb.wr_data & `PIEF_MASK_ENABLE_THREE;
        end
        if (wr_four) begin
            // masking keeps the unimplemented bits at zero so they read back zero
            next_enable_four = rb.wr_data & `PIEF_MASK_ENABLE_FOUR;
        end
        if (wr_ctrl) begin
            next_control = rb.wr_data & `PIEF_MASK_CONTROL;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_two <= `PIEF_RESET_VALUE;
            enable_three <= `PIEF_RESET_VALUE;
            enable_four <= `PIEF_RESET_VALUE;
            control <= `PIEF_RESET_VALUE;
        end else begin
            enable_two <= next_enable_two;
            enable_three <= next_enable_three;
            enable_four <= next_enable_four;
            control <= next_control;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // request register one
    pief_byte_t request_one;

    pief_pending_flags #(
        .WIDTH(8),
        .RW_MASK(`PIEF_MASK_REQUEST_ONE_RW)
    ) u_request_one (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_in(request_one_src),
        .wr_en(wr_req_one),
        .wr_data(rb.wr_data),
        .flags(request_one)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        rb.rd_hit = 1'b1;
        case (rd_word)
            `PIEF_OFF_ENABLE_TWO: rb.rd_data = enable_two;
            `PIEF_OFF_ENABLE_THREE: rb.rd_data = enable_three;
            `PIEF_OFF_ENABLE_FOUR: rb.rd_data = enable_four;
            `PIEF_OFF_REQUEST_ONE: rb.rd_data = request_one;
            `PIEF_OFF_CONTROL: rb.rd_data = control;
            default: begin
                rb.rd_hit = 1'b0;
                rb.rd_data = 8'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // combined request; neighbour flags are masked here so a stray high bit
    // on an unimplemented position can never raise the request
    logic global_en, periph_en, any_enabled, next_irq;

    assign global_en = control[`PIEF_BIT_GLOBAL_EN];
    assign periph_en = control[`PIEF_BIT_PERIPH_EN];
    assign any_enabled = |(request_one & 8'h00) // enable one lives in a neighbouring block
        | |(pending_two & enable_two)
        | |(pending_three & enable_three)
        | |(pending_four & enable_four);
    assign next_irq = global_en && periph_en && any_enabled;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            peripheral_irq <= 1'b0;
        end else begin
            peripheral_irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_two_write_lands: assert property (
        wr_two |=> enable_two == $past(rb.wr_data))
        else $error("enable two did not take written value");

    a_three_unimpl_zero: assert property (
        (enable_three & ~`PIEF_MASK_ENABLE_THREE) == 8'h00)
        else $error("enable three unimplemented bit set");

    a_four_unimpl_zero: assert property (
        wr_four |=> enable_four[7] == 1'b0 && enable_four[3] == 1'b0
            && enable_four[6:4] == $past(rb.wr_data[6:4]))
        else $error("enable four timebase field wrong");

    a_four_shutdown_write: assert property (
        wr_four |=> enable_four[2:0] == $past(rb.wr_data[2:0]))
        else $error("enable four shutdown field wrong");

    a_periph_blocks_irq: assert property (
        !periph_en |=> !peripheral_irq)
        else $error("request passed with peripheral enable clear");

    a_global_blocks_irq: assert property (
        !global_en [*2] |-> !peripheral_irq)
        else $error("request passed with global enable clear");

    a_irq_has_cause: assert property (
        peripheral_irq |-> $past(global_en && periph_en && any_enabled))
        else $error("request without enabled pending flag");

    a_irq_follows_cause: assert property (
        global_en && periph_en && |(pending_two & enable_two) |=> peripheral_irq)
        else $error("enabled flag did not raise request");

    a_set_beats_clear: assert property (
        request_one_src[0] && wr_req_one && !rb.wr_data[0] |=> request_one[0])
        else $error("flag event lost against clear");

    a_rx_read_only: assert property (
        wr_req_one |=> request_one[`PIEF_BIT_SERIAL_RX] == $past(request_one_src[5]))
        else $error("receive flag changed by write");

    a_reset_clears: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> enable_two == 8'h00 && enable_three == 8'h00 && enable_four == 8'h00
            && request_one == 8'h00
            && control == 8'h00 && !peripheral_irq)
        else $error("state not cleared by reset");

    c_irq_raised: cover property (
        global_en && periph_en ##1 $rose(peripheral_irq));
    c_set_and_clear: cover property (
        request_one_src[1] && wr_req_one && !rb.wr_data[1]);
    c_bad_address: cover property (
        s_axi_bvalid && s_axi_bresp == `PIEF_RESP_SLVERR);
    c_read_request: cover property (
        s_axi_rvalid && s_axi_rready && rd_word == `PIEF_OFF_REQUEST_ONE);
endmodule

//--- verification/pief_event_src.sv
// far-side model: peripheral event pulses, serial status levels, neighbouring pending flags
`timescale 1ns/10ps
module pief_event_src (
    input wire logic aclk,
    output pief_pkg::pief_byte_t request_one_src,
    output pief_pkg::pief_byte_t pending_two,
    output pief_pkg::pief_byte_t pending_three,
    output pief_pkg::pief_byte_t pending_four
);
    import pief_pkg::*;
    pief_byte_t pulse_bits = 8'h00;
    pief_byte_t level_bits = 8'h00;

    // status bits are live levels; every other source is a one-cycle event
    assign request_one_src = pulse_bits | level_bits;

    initial begin
        pending_two = 8'h00;
        pending_three = 8'h00;
        pending_four = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic fire(input pief_byte_t mask);
        @(posedge aclk);
        pulse_bits <= mask & 8'hcf;
        @(posedge aclk);
        pulse_bits <= 8'h00;
    endtask

    task automatic set_status(input pief_byte_t lv);
        @(posedge aclk);
        level_bits <= lv & 8'h30;
    endtask

    task automatic set_pending(input pief_byte_t p2, input pief_byte_t p3, input pief_byte_t p4);
        @(posedge aclk);
        pending_two <= p2;
        pending_three <= p3;
        pending_four <= p4;
    endtask
endmodule

//--- verification/peripheral_irq_enable_flag_bank_test.sv
// self-checking bench for the irq enable/flag bank
`timescale 1ns/10ps
`include "pief_defines.svh"
module peripheral_irq_enable_flag_bank_test;
    import pief_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    pief_addr_t awaddr = 8'h00;
    pief_addr_t araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, peripheral_irq;
    pief_resp_t bresp, rresp;
    logic [31:0] rdata;
    pief_byte_t src, p2, p3, p4;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    int seed = 32'hab6726f0;
    logic [7:0] mdl [0:4];
    logic [7:0] lvl = 8'h00;
    localparam logic [7:0] OFF [0:4] = '{`PIEF_OFF_ENABLE_TWO, `PIEF_OFF_ENABLE_THREE,
        `PIEF_OFF_ENABLE_FOUR, `PIEF_OFF_REQUEST_ONE, `PIEF_OFF_CONTROL};
    localparam logic [7:0] MASK [0:4] = '{8'hff, 8'h10, 8'h77, 8'hcf, 8'hc0};

    initial begin
        forever #2 aclk = ~aclk;
    end

    pief_bank u_pief_bank (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .request_one_src(src), .pending_two(p2), .pending_three(p3), .pending_four(p4),
        .peripheral_irq(peripheral_irq)
    );

    pief_event_src u_pief_event_src (
        .aclk(aclk), .request_one_src(src), .pending_two(p2), .pending_three(p3),
        .pending_four(p4)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] expect_rd(input int i);
        return (i == 3) ? ((mdl[3] & 8'hcf) | (lvl & 8'h30)) : mdl[i];
    endfunction

    function automatic logic exp_irq();
        return mdl[4][7] & mdl[4][6] & (|((mdl[0] & p2) | (mdl[1] & p3) | (mdl[2] & p4)));
    endfunction

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // master holds each channel until its own handshake edge
    task automatic axi_write(input pief_addr_t addr, input logic [7:0] data, output pief_resp_t resp);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= addr;
        wdata <= {24'h0, data};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                resp = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic axi_read(input pief_addr_t addr, output logic [31:0] data, output pief_resp_t resp);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                data = rdata;
                resp = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic wr(input int i, input logic [7:0] data);
        pief_resp_t resp;
        axi_write(OFF[i], data, resp);
        mdl[i] = data & MASK[i];
        check({30'h0, resp}, 32'h0, "write response");
    endtask

    task automatic rd_check(input int i);
        pief_resp_t resp;
        logic [31:0] d;
        axi_read(OFF[i], d, resp);
        check(d, {24'h0, expect_rd(i)}, "read data");
        check({30'h0, resp}, 32'h0, "read response");
    endtask

    task automatic irq_check();
        repeat (3) @(posedge aclk);
        check({31'h0, peripheral_irq}, {31'h0, exp_irq()}, "combined request");
    endtask

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            miscompares++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pief_resp_t resp;
        logic [31:0] d;
        logic [7:0] pm;
        foreach (mdl[i]) mdl[i] = 8'h00;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd_check(i);
        $display("test reset values done");
        for (int n = 0; n < 4; n++) begin
            for (int i = 0; i < 5; i++) begin
                wr(i, (n == 0) ? 8'hff : 8'($random(seed)));
                rd_check(i);
            end
        end
        $display("test register access done");
        axi_write(8'h14, 8'hff, resp);
        check({30'h0, resp}, 32'h2, "unmapped write response");
        axi_read(8'h14, d, resp);
        check(d, 32'h0, "unmapped read data");
        check({30'h0, resp}, 32'h2, "unmapped read response");
        for (int i = 0; i < 5; i++) rd_check(i);
        // a write with byte lane 0 off must leave the register as it was
        wstrb <= 4'he;
        axi_write(OFF[0], 8'h5a, resp);
        wstrb <= 4'hf;
        check({30'h0, resp}, 32'h0, "masked write response");
        rd_check(0);
        $display("test unmapped access done");
        wr(4, 8'h00);
        wr(3, 8'hff);
        rd_check(3);
        wr(3, 8'h00);
        for (int b = 0; b < 8; b++) begin
            if (b == 4 || b == 5) continue;
            u_pief_event_src.fire(8'h01 << b);
            mdl[3][b] = 1'b1;
            rd_check(3);
        end
        u_pief_event_src.set_status(8'h30);
        lvl = 8'h30;
        rd_check(3);
        wr(3, 8'h00);
        rd_check(3);
        u_pief_event_src.set_status(8'h00);
        lvl = 8'h00;
        rd_check(3);
        // event pulse lands on the same edge as the clearing write: the set must win
        fork
            wr(3, 8'h00);
            begin
                @(posedge aclk);
                u_pief_event_src.fire(8'h03);
            end
        join
        mdl[3] = 8'h03;
        rd_check(3);
        $display("test request flags done");
        for (int k = 0; k < 12; k++) begin
            pm = k[2] ? 8'h00 : 8'hff;
            u_pief_event_src.set_pending(8'($random(seed)) & pm, 8'($random(seed)) & pm,
                8'($random(seed)) & pm);
            for (int i = 0; i < 3; i++) wr(i, 8'($random(seed)));
            wr(4, {k[1:0], 6'h00});
            irq_check();
        end
        $display("test combined request done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        check({31'h0, peripheral_irq}, 32'h0, "request in reset");
        aresetn <= 1'b1;
        foreach (mdl[i]) mdl[i] = 8'h00;
        for (int i = 0; i < 5; i++) rd_check(i);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule
